//--- hdl/lin_frame_regs.vh
`ifndef LIN_FRAME_REGS_VH
`define LIN_FRAME_REGS_VH
// bit timing: cycles per bit and sample phases in baud generator cycles, the rest in bits
`define LIN_OVS        16
`define LIN_SMP1       5'h07
`define LIN_SMP2       5'h08
`define LIN_SMP3       5'h09
`define LIN_STOP_IDX   4'h9
`define LIN_FIELD_BITS  6'h0a
`define LIN_FIELD_BITS2 6'h0b
`define LIN_TMO_BITS   14
// field constants
`define LIN_SYNC_BYTE  8'h55
`define LIN_BRK_BASE   6'h0a
`define LIN_BRK_LIN_MAX 4'hd
`define LIN_BRK_CODE_E 4'he
`define LIN_BRK_E      6'h24
`define LIN_BRK_F      6'h32
`define LIN_FI_PID     4'h1
`define LIN_FI_DATA    4'h2
`define LIN_FI_CKS_OFS 4'h3
// channel register byte offsets (channel base = channel * 0x40)
`define REG_CTRL   6'h00
`define REG_CFG    6'h04
`define REG_ID     6'h08
`define REG_BCTL   6'h0c
`define REG_CKS    6'h10
`define REG_STAT   6'h14
`define REG_ERR    6'h18
`define REG_IE     6'h1c
`define REG_DATA0  6'h20
`define REG_DATA1  6'h24
// global registers
`define REG_GHREQ  12'h100
`define REG_GIEN   12'h104
`define REG_GINT   12'h108
// field positions
`define CFG_MBL_LO 3
`define CFG_CCD    7
`define CFG_STOP2  8
`define BC_DIR     0
`define BC_CCS     1
`define BC_DFL_LO  2
`define ST_TXC     0
`define ST_RXC     1
`define ST_RBNE    2
`define ST_BUSY    7
`define ER_BIT     0
`define ER_CKS     1
`define ER_FRM     2
`define ER_TMO     3
// reset values
`define CFG_RST    9'h000
`define BCTL_RST   5'h00
`define IE_RST     6'h00
`define GIEN_RST   8'h00
`endif

//--- hdl/lin_bit_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"
module lin_bit_engine #(
	parameter OVS = `LIN_OVS
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       rxd_i,
	input  wire       tx_go_i,
	input  wire       tx_brk_i,
	input  wire [7:0] tx_byte_i,
	input  wire [5:0] brk_bits_i,
	input  wire       stop2_i,
	output reg        txd_o,
	output reg        tx_take_o,
	output reg        tx_done_o,
	output reg        rx_valid_o,
	output reg  [7:0] rx_byte_o,
	output reg        rx_ferr_o
);
	localparam integer PH_FULL = OVS - 1;
	localparam [4:0] PH_LAST = PH_FULL[4:0];
	reg  [4:0]  tx_ph_r;
	reg  [5:0]  tx_left_r;
	reg  [10:0] tx_sh_r;
	reg         tx_busy_r;
	reg         tx_brk_r;
	reg  [4:0]  rx_ph_r;
	reg  [3:0]  rx_bit_r;
	reg         rx_busy_r;
	reg         rx_prev_r;
	reg  [1:0]  smp_r;
	reg  [7:0]  rx_sh_r;
	wire        maj;
	wire        rx_arm;

	assign maj    = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxd_i) | (smp_r[1] & rxd_i);
	assign rx_arm = ~(tx_busy_r & tx_brk_r);

	////////////////////////////////////////////////////////////////////////////
	// transmitter: break or one byte field, lsb first
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_ph_r   <= 5'h00;
			tx_left_r <= 6'h00;
			tx_sh_r   <= 11'h7ff;
			tx_busy_r <= 1'b0;
			tx_brk_r  <= 1'b0;
			txd_o     <= 1'b1;
			tx_take_o <= 1'b0;
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= 1'b0;
			tx_take_o <= 1'b0;
			if (!tx_busy_r) begin
				if (tx_go_i) begin
					tx_busy_r <= 1'b1;
					tx_take_o <= 1'b1;
					tx_brk_r  <= tx_brk_i;
					tx_ph_r   <= 5'h00;
					tx_left_r <= tx_brk_i ? brk_bits_i + 6'h01 :
						(stop2_i ? `LIN_FIELD_BITS2 : `LIN_FIELD_BITS);
					tx_sh_r   <= {2'b11, tx_byte_i, 1'b0};
					txd_o     <= 1'b0;
				end
			end else if (tx_ph_r == PH_LAST) begin
				tx_ph_r <= 5'h00;
				if (tx_left_r == 6'h01) begin
					tx_busy_r <= 1'b0;
					tx_done_o <= 1'b1;
					txd_o     <= 1'b1;
				end else begin
					tx_left_r <= tx_left_r - 6'h01;
					tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
					// a break ends with one recessive delimiter bit
					txd_o     <= tx_brk_r ? (tx_left_r == 6'h02) : tx_sh_r[1];
				end
			end else begin
				tx_ph_r <= tx_ph_r + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receiver: 16 cycles a bit, three samples mid bit
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_ph_r    <= 5'h00;
			rx_bit_r   <= 4'h0;
			rx_busy_r  <= 1'b0;
			rx_prev_r  <= 1'b1;
			smp_r      <= 2'b11;
			rx_sh_r    <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_byte_o  <= 8'h00;
			rx_ferr_o  <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			rx_prev_r  <= rxd_i;
			if (!rx_busy_r) begin
				if (rx_arm && rx_prev_r && !rxd_i) begin
					rx_busy_r <= 1'b1;
					rx_ph_r   <= 5'h00;
					rx_bit_r  <= 4'h0;
				end
			end else begin
				rx_ph_r <= (rx_ph_r == PH_LAST) ? 5'h00 : rx_ph_r + 5'h01;
				if (rx_ph_r == `LIN_SMP1)
					smp_r[0] <= rxd_i;
				if (rx_ph_r == `LIN_SMP2)
					smp_r[1] <= rxd_i;
				if (rx_ph_r == `LIN_SMP3) begin
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r == 4'h0) begin
						if (maj)
							rx_busy_r <= 1'b0; // glitch, not a start bit
					end else if (rx_bit_r == `LIN_STOP_IDX) begin
						rx_busy_r  <= 1'b0;
						rx_valid_o <= 1'b1;
						rx_byte_o  <= rx_sh_r;
						rx_ferr_o  <= ~maj;
					end else begin
						rx_sh_r <= {maj, rx_sh_r[7:1]};
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- hdl/lin_commander_frame_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"
// Overview of operation
// - writing the header request bit sends break, sync and protected identifier
// - after the header, direction bit 1 transmits the response, 0 receives it
// - transmitted response sends buffer bytes, count from data length, then checksum
// - each channel has separate 8-byte transmit and receive buffers
// - checksum disable clear: hardware checksum; set: software checksum field is sent
// - checksum type bit picks enhanced or classic hardware checksum
// - transmitted identifier and data are read back and copied to the identifier field and the receive buffer
// - received bytes go to the receive buffer, received checksum to checksum field
// - with checksum disable clear, received checksum is checked against computed one
// - a good frame sets transmit-complete or receive-complete by direction
// - any error aborts the frame and sets an error flag, not completion
// - all flags but buffer-not-empty are maskable by channel and global enables
// - new header request accepted only once the current frame has finished
// - a byte field is start bit, eight data bits, stop bit; with CFG_STOP2 set, two stop bits are sent
// - each received bit spans 16 baud generator cycles
// - reception syncs on the start bit falling edge within one cycle
// - three mid-bit samples, majority decides the bit value
// - four independent channels
// - 4-bit break length: codes 0..13 give 10..23 bits, 14 gives 36, 15 gives 50
// - header request bits clear themselves and always read as zero
// - writing 1 to a completion or error flag clears it; buffer-not-empty clears only on a header request
module lin_commander_frame_engine #(
	parameter OVS      = `LIN_OVS,
	parameter TMO_BITS = `LIN_TMO_BITS
) (
	input  wire        REF_CLK_I,
	input  wire        RST_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output reg         PREADY_O,
	output reg         PSLVERR_O,
	input  wire [3:0]  LIN_RXD_I,
	output wire [3:0]  LIN_TXD_O,
	output reg         IRQ_O
);
	localparam NCH = 4;
	localparam integer TMO_FULL = TMO_BITS * OVS;
	localparam [9:0] TMO_CYC = TMO_FULL[9:0];
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_BRK  = 2'h1;
	localparam [1:0] S_TXF  = 2'h2;
	localparam [1:0] S_RXF  = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function [7:0] pid_of;
		input [5:0] id;
		begin
			pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		end
	endfunction

	function [7:0] cks_add;
		input [7:0] s;
		input [7:0] b;
		reg   [8:0] t;
		begin
			t       = {1'b0, s} + {1'b0, b};
			cks_add = t[7:0] + {7'h00, t[8]};
		end
	endfunction

	function [5:0] brk_len;
		input [3:0] code;
		begin
			if (code <= `LIN_BRK_LIN_MAX)
				brk_len = `LIN_BRK_BASE + {2'b00, code};
			else if (code == `LIN_BRK_CODE_E)
				brk_len = `LIN_BRK_E;
			else
				brk_len = `LIN_BRK_F;
		end
	endfunction

	function reg_hit;
		input [11:0] a;
		begin
			if (a[11:8] == 4'h0)
				reg_hit = (a[5:0] <= `REG_DATA1) && (a[1:0] == 2'b00);
			else
				reg_hit = (a == `REG_GHREQ) || (a == `REG_GIEN) || (a == `REG_GINT);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb slave, one wait state
	wire        apb_take;
	wire        wr_stb;
	wire        g_hreq;
	wire [127:0] rd_all;
	wire [3:0]  si_all;
	wire [3:0]  ei_all;
	wire [7:0]  int3;
	reg  [7:0]  gien_r;
	reg  [3:0]  rx_m_r;
	reg  [3:0]  rx_s_r;
	reg  [31:0] rd_mux;

	assign apb_take = PSEL_I & PENABLE_I & ~PREADY_O;
	assign wr_stb   = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	assign g_hreq   = wr_stb & (PADDR_I == `REG_GHREQ);
	assign int3     = {ei_all, si_all};

	always @* begin
		if (PADDR_I == `REG_GIEN)
			rd_mux = {24'h000000, gien_r};
		else if (PADDR_I == `REG_GINT)
			rd_mux = {24'h000000, int3};
		else if (PADDR_I[11:8] == 4'h0)
			rd_mux = rd_all[{PADDR_I[7:6], 5'h00} +: 32];
		else
			rd_mux = 32'h00000000; // header request reads zero
	end

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h00000000;
			gien_r    <= `GIEN_RST;
			IRQ_O     <= 1'b0;
			rx_m_r    <= 4'hf;
			rx_s_r    <= 4'hf;
		end else begin
			PREADY_O  <= apb_take;
			PSLVERR_O <= apb_take & ~reg_hit(PADDR_I);
			if (apb_take && !PWRITE_I)
				PRDATA_O <= reg_hit(PADDR_I) ? rd_mux : 32'h00000000;
			if (wr_stb && PADDR_I == `REG_GIEN)
				gien_r <= PWDATA_I[7:0];
			IRQ_O  <= |(int3 & gien_r);
			rx_m_r <= LIN_RXD_I;
			rx_s_r <= rx_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// channels
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : chan
			localparam integer CH_NUM = g;
			localparam [1:0] CH = CH_NUM[1:0];
			reg  [8:0]  cfg_r;
			reg  [5:0]  id_r;
			reg  [4:0]  bc_r;
			reg  [7:0]  cks_r;
			reg  [2:0]  st_r;
			reg  [3:0]  er_r;
			reg  [5:0]  ie_r;
			reg  [63:0] txb_r;
			reg  [63:0] rxb_r;
			reg  [1:0]  state_r;
			reg  [3:0]  fi_r;
			reg  [7:0]  sum_r;
			reg  [9:0]  tmo_r;
			reg         tx_go_r;
			reg         tx_brk_r;
			reg  [7:0]  tx_byte_r;
			reg  [31:0] rd;
			reg  [7:0]  sum_n;
			reg  [7:0]  nxt_byte;
			wire        tx_take;
			wire        tx_done;
			wire        rx_valid;
			wire        rx_ferr;
			wire [7:0]  rx_byte;
			wire        wsel;
			wire        hreq;
			wire        dir;
			wire        ccd;
			wire [3:0]  last;
			wire [3:0]  nf;
			wire [3:0]  nfm;
			wire [3:0]  fim;

			assign wsel = wr_stb & (PADDR_I[11:8] == 4'h0) & (PADDR_I[7:6] == CH);
			assign hreq = (wsel & (PADDR_I[5:0] == `REG_CTRL) & PWDATA_I[0]) | (g_hreq & PWDATA_I[g]);
			assign dir  = bc_r[`BC_DIR];
			assign ccd  = cfg_r[`CFG_CCD];
			assign last = {1'b0, bc_r[`BC_DFL_LO +: 3]} + `LIN_FI_CKS_OFS;
			assign nf   = fi_r + 4'h1;
			assign nfm  = nf - `LIN_FI_DATA;
			assign fim  = fi_r - `LIN_FI_DATA;
			assign si_all[g] = |(st_r[1:0] & ie_r[1:0]);
			assign ei_all[g] = |(er_r & ie_r[5:2]);
			assign rd_all[32*g +: 32] = rd;

			always @* begin
				if (fi_r == `LIN_FI_PID)
					sum_n = bc_r[`BC_CCS] ? rx_byte : 8'h00;
				else if (fi_r >= `LIN_FI_DATA && fi_r < last)
					sum_n = cks_add(sum_r, rx_byte);
				else
					sum_n = sum_r;
				if (nf == `LIN_FI_PID)
					nxt_byte = pid_of(id_r);
				else if (nf == last)
					nxt_byte = ccd ? cks_r : ~sum_n;
				else
					nxt_byte = txb_r[{nfm[2:0], 3'b000} +: 8];
			end

			always @* begin
				case (PADDR_I[5:0])
					`REG_CFG:   rd = {23'h000000, cfg_r};
					`REG_ID:    rd = {26'h0000000, id_r};
					`REG_BCTL:  rd = {27'h0000000, bc_r};
					`REG_CKS:   rd = {24'h000000, cks_r};
					`REG_STAT:  rd = {24'h000000, state_r != S_IDLE, 4'h0, st_r};
					`REG_ERR:   rd = {28'h0000000, er_r};
					`REG_IE:    rd = {26'h0000000, ie_r};
					`REG_DATA0: rd = rxb_r[31:0];
					`REG_DATA1: rd = rxb_r[63:32];
					default:    rd = 32'h00000000;
				endcase
			end

			always @(posedge REF_CLK_I or posedge RST_I) begin
				if (RST_I) begin
					cfg_r     <= `CFG_RST;
					id_r      <= 6'h00;
					bc_r      <= `BCTL_RST;
					cks_r     <= 8'h00;
					st_r      <= 3'h0;
					er_r      <= 4'h0;
					ie_r      <= `IE_RST;
					txb_r     <= 64'h0000000000000000;
					rxb_r     <= 64'h0000000000000000;
					state_r   <= S_IDLE;
					fi_r      <= 4'h0;
					sum_r     <= 8'h00;
					tmo_r     <= 10'h000;
					tx_go_r   <= 1'b0;
					tx_brk_r  <= 1'b0;
					tx_byte_r <= 8'h00;
				end else begin
					if (tx_take)
						tx_go_r <= 1'b0;
					if (wsel) begin
						case (PADDR_I[5:0])
							`REG_CFG:   cfg_r <= PWDATA_I[8:0];
							`REG_ID:    id_r  <= PWDATA_I[5:0];
							`REG_BCTL:  bc_r  <= PWDATA_I[4:0];
							`REG_CKS:   if (ccd) cks_r <= PWDATA_I[7:0];
							`REG_STAT:  st_r[1:0] <= st_r[1:0] & ~PWDATA_I[1:0];
							`REG_ERR:   er_r <= er_r & ~PWDATA_I[3:0];
							`REG_IE:    ie_r <= PWDATA_I[5:0];
							`REG_DATA0: txb_r[31:0]  <= PWDATA_I;
							`REG_DATA1: txb_r[63:32] <= PWDATA_I;
							default:    ;
						endcase
					end
					// flag sets below come after the clears, so a set wins
					case (state_r)
						S_IDLE: begin
							if (hreq) begin
								state_r      <= S_BRK;
								tx_go_r      <= 1'b1;
								tx_brk_r     <= 1'b1;
								fi_r         <= 4'h0;
								sum_r        <= 8'h00;
								st_r[`ST_RBNE] <= 1'b0;
							end
						end
						S_BRK: begin
							if (tx_done) begin
								state_r   <= S_TXF;
								tx_go_r   <= 1'b1;
								tx_brk_r  <= 1'b0;
								tx_byte_r <= `LIN_SYNC_BYTE;
								tmo_r     <= 10'h000;
							end
						end
						default: begin
							tmo_r <= tmo_r + 10'h001;
							if (rx_valid) begin
								tmo_r <= 10'h000;
								sum_r <= sum_n;
								fi_r  <= nf;
								if (rx_ferr) begin
									er_r[`ER_FRM] <= 1'b1;
									state_r <= S_IDLE;
									tx_go_r <= 1'b0;
								end else if (state_r == S_TXF && rx_byte != tx_byte_r) begin
									er_r[`ER_BIT] <= 1'b1;
									state_r <= S_IDLE;
									tx_go_r <= 1'b0;
								end else begin
									if (fi_r == `LIN_FI_PID)
										id_r <= rx_byte[5:0];
									if (fi_r >= `LIN_FI_DATA && fi_r < last) begin
										rxb_r[{fim[2:0], 3'b000} +: 8] <= rx_byte;
										if (!dir)
											st_r[`ST_RBNE] <= 1'b1;
									end
									if (fi_r == last) begin
										state_r <= S_IDLE;
										if (dir) begin
											st_r[`ST_TXC] <= 1'b1;
										end else begin
											cks_r <= rx_byte;
											if (!ccd && rx_byte != ~sum_r)
												er_r[`ER_CKS] <= 1'b1;
											else
												st_r[`ST_RXC] <= 1'b1;
										end
									end else if (nf < `LIN_FI_DATA || dir) begin
										state_r   <= S_TXF;
										tx_go_r   <= 1'b1;
										tx_byte_r <= nxt_byte;
									end else begin
										state_r <= S_RXF;
									end
								end
							end else if (tmo_r == TMO_CYC) begin
								er_r[`ER_TMO] <= 1'b1;
								state_r <= S_IDLE;
								tx_go_r <= 1'b0;
							end
						end
					endcase
				end
			end

			lin_bit_engine #(
				.OVS (OVS)
			) u_bits (
				.clk_i      (REF_CLK_I),
				.rst_i      (RST_I),
				.rxd_i      (rx_s_r[g]),
				.tx_go_i    (tx_go_r),
				.tx_brk_i   (tx_brk_r),
				.tx_byte_i  (tx_byte_r),
				.brk_bits_i (brk_len(cfg_r[`CFG_MBL_LO +: 4])),
				.stop2_i    (cfg_r[`CFG_STOP2]),
				.txd_o      (LIN_TXD_O[g]),
				.tx_take_o  (tx_take),
				.tx_done_o  (tx_done),
				.rx_valid_o (rx_valid),
				.rx_byte_o  (rx_byte),
				.rx_ferr_o  (rx_ferr)
			);
		end
	endgenerate
endmodule
`default_nettype wire

//--- tb/lin_frame_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lin_frame_chk #(
	parameter OVS = 16
) (
	input wire logic        REF_CLK_I,
	input wire logic        RST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic [3:0]  LIN_TXD_O,
	input wire logic        IRQ_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	logic [9:0]  lowc_r;
	logic [10:0] highc_r;
	wire         acc = PSEL_I && PENABLE_I && PREADY_O;
	////////////////////////////////////////
	// run lengths on channel 0; a saturated high count means the channel is idle
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lowc_r  <= 10'h000;
			highc_r <= 11'h000;
		end else begin
			lowc_r  <= LIN_TXD_O[0] ? 10'h000 : lowc_r + 10'h001;
			highc_r <= !LIN_TXD_O[0] ? 11'h000 : (&highc_r) ? highc_r : highc_r + 11'h001;
		end
	end
	////////////////////////////////////////
	a_hdr_reads_zero: assert property (acc && !PWRITE_I && (PADDR_I == 12'h100 || PADDR_I[11:6] < 6'h04 && PADDR_I[5:0] == 6'h00) |-> PRDATA_O == 32'h0)
		else $error("header request register read nonzero");
	a_bit_multiple: assert property ($rose(LIN_TXD_O[0]) |-> lowc_r != 10'h000 && lowc_r % OVS == 0)
		else $error("low run not a whole number of bits");
	a_break_min: assert property ($rose(LIN_TXD_O[0]) && lowc_r > 10'h090 |-> lowc_r >= 10'h0a0)
		else $error("break shorter than ten bits");
	a_break_max: assert property (lowc_r <= 10'h320)
		else $error("line low longer than fifty bits");
	a_hdr_start: assert property (acc && PWRITE_I && PADDR_I == 12'h000 && PWDATA_I[0] && (&highc_r) |-> ##[2:3] !LIN_TXD_O[0])
		else $error("header request did not start a break");
	a_wait_state: assert property (PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |-> !PREADY_O ##1 PREADY_O)
		else $error("answer not after exactly one wait state");
	a_prdata_hold: assert property ($changed(PRDATA_O) |-> acc && !PWRITE_I)
		else $error("read data changed outside a read answer");
	a_reset_idle: assert property ($fell(RST_I) |-> LIN_TXD_O == 4'hf && !IRQ_O && !PREADY_O && !PSLVERR_O)
		else $error("outputs not idle after reset");
	c_irq: cover property ($rose(IRQ_O));
	c_unmapped: cover property (acc && PSLVERR_O);
	c_long_break: cover property ($rose(LIN_TXD_O[0]) && lowc_r == 10'h320);
endmodule
bind lin_commander_frame_engine lin_frame_chk #(.OVS(OVS)) i_lin_frame_chk (
	.REF_CLK_I (REF_CLK_I),
	.RST_I     (RST_I),
	.PSEL_I    (PSEL_I),
	.PENABLE_I (PENABLE_I),
	.PWRITE_I  (PWRITE_I),
	.PADDR_I   (PADDR_I),
	.PWDATA_I  (PWDATA_I),
	.PRDATA_O  (PRDATA_O),
	.PREADY_O  (PREADY_O),
	.PSLVERR_O (PSLVERR_O),
	.LIN_TXD_O (LIN_TXD_O),
	.IRQ_O     (IRQ_O)
);
`default_nettype wire

//--- tb/lin_responder_model.sv
`timescale 1ns/1ps
`default_nettype none
module lin_responder_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        line_i,
	input  wire logic        arm_i,
	input  wire logic [7:0]  gap_i,
	input  wire logic [3:0]  resp_n_i,
	input  wire logic [71:0] resp_i,
	output var  logic        drv_low_o
);
	logic [7:0] seen [$];
	logic [8:0] v;
	int         brk_cycles = 0;
	int         n_brk = 0;
	int         n;
	// drives low only; released line returns to the pull-up level
	task send;
		logic [9:0] f;
		repeat (8 + gap_i) @(posedge clk_i);
		for (int b = 0; b < resp_n_i; b++) begin
			f = {1'b1, resp_i[8*b +: 8], 1'b0};
			for (int i = 0; i < 10; i++) begin
				drv_low_o <= ~f[i];
				repeat (16) @(posedge clk_i);
			end
		end
		drv_low_o <= 1'b0;
	endtask
	initial begin
		drv_low_o = 1'b0;
		wait (rst_i === 1'b0);
		forever begin
			@(negedge line_i);
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (16) @(posedge clk_i);
				v[i] = line_i;
			end
			if (!v[8]) begin
				n = 152;
				while (!line_i) begin
					@(posedge clk_i);
					n++;
				end
				brk_cycles = n;
				n_brk++;
				seen.delete();
			end else begin
				seen.push_back(v[7:0]);
				if (arm_i && seen.size() == 2) send;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/lin_commander_frame_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lin_commander_frame_engine_tb;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, drv_low, arm, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [3:0]  txd, rxd, resp_n;
	logic [1:0]  sel;
	logic [7:0]  gap;
	logic [71:0] resp;
	logic [5:0]  offs [6] = '{6'h00, 6'h04, 6'h0c, 6'h14, 6'h18, 6'h1c};
	int          n_errors = 0;
	int          compares = 0;
	assign rxd = txd & ~(4'(drv_low) << sel);
	lin_commander_frame_engine i_lin_commander_frame_engine (
		.REF_CLK_I (clk), .RST_I (rst), .PSEL_I (psel), .PENABLE_I (penable), .PWRITE_I (pwrite),
		.PADDR_I (paddr), .PWDATA_I (pwdata), .PRDATA_O (prdata), .PREADY_O (pready),
		.PSLVERR_O (pslverr), .LIN_RXD_I (rxd), .LIN_TXD_O (txd), .IRQ_O (irq)
	);
	lin_responder_model i_resp (
		.clk_i (clk), .rst_i (rst), .line_i (rxd[sel]), .arm_i (arm), .gap_i (gap),
		.resp_n_i (resp_n), .resp_i (resp), .drv_low_o (drv_low)
	);
	////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] cks_of(input logic enh, input logic [7:0] pid, input logic [7:0] q [$]);
		int s;
		s = enh ? pid : 0;
		foreach (q[i]) begin
			s = s + q[i];
			if (s > 255) s = s - 255;
		end
		return 8'(~s);
	endfunction
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task end_of_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	task frame(input int k);
		logic [31:0] r, d0, d1;
		logic [7:0]  q [$];
		logic [7:0]  pid, ck, rck;
		logic [11:0] base;
		logic [5:0]  id;
		logic [3:0]  brk, err;
		logic        dir, enh, ccd, ie;
		int          ch, nb, mode, nbrk, n;
		q.delete();
		ch = k % 4;
		brk = 4'(15 - k);
		dir = k[0];
		enh = k[2];
		ccd = (k == 5 || k == 14);
		ie = k[3];
		mode = dir ? 0 : (k / 2) % 3;
		nb = (k == 3) ? 8 : (k == 1) ? 1 : int'(xs() % 8) + 1;
		id = 6'(xs());
		d0 = xs();
		d1 = xs();
		for (int i = 0; i < nb; i++) q.push_back(8'({d1, d0} >> (8 * i)));
		pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		ck = ccd ? 8'(xs()) : cks_of(enh, pid, q);
		rck = (mode == 1) ? ck ^ 8'h01 : ck;
		err = (mode == 2) ? 4'h8 : (mode == 1 && !ccd) ? 4'h2 : 4'h0;
		base = 12'(ch * 64);
		sel <= 2'(ch);
		arm <= !dir && mode != 2;
		gap <= ie ? 8'h3c : 8'h14;
		resp_n <= 4'(nb + 1);
		resp <= 72'({d1, d0} & ((64'h1 << (8 * nb)) - 64'h1)) | (72'(rck) << (8 * nb));
		wr(base + 12'h004, {23'h0, k[1] & k[0], ccd, brk, 3'h0});
		wr(base + 12'h008, {26'h0, id});
		wr(base + 12'h00c, {27'h0, 3'(nb - 1), enh, dir});
		wr(base + 12'h020, d0);
		wr(base + 12'h024, d1);
		if (ccd) wr(base + 12'h010, {24'h0, ck});
		wr(base + 12'h01c, 32'h3f);
		wr(12'h104, ie ? (32'h11 << ch) : 32'h0);
		nbrk = i_resp.n_brk;
		// identifier and buffer control stay untouched until the frame ends
		if (k[1]) wr(12'h100, 32'h1 << ch);
		else wr(base, 32'h1);
		apb(1'b0, base + 12'h014, 0, r);
		chk("busy", r[7], 1'b1);
		wr(base, 32'h1);
		n = 0;
		do begin
			apb(1'b0, base + 12'h014, 0, r);
			n++;
		end while (r[7] !== 1'b0 && n < 2000);
		chk("idle", r[7], 1'b0);
		chk("breaks", i_resp.n_brk - nbrk, 1);
		chk("break bits", (i_resp.brk_cycles + 8) / 16, brk <= 13 ? 10 + brk : brk == 14 ? 36 : 50);
		chk("sync", i_resp.seen[0], 8'h55);
		chk("pid", i_resp.seen[1], pid);
		if (dir) begin
			for (int i = 0; i < nb; i++) chk("tx data", i_resp.seen[2 + i], q[i]);
			chk("tx cks", i_resp.seen[2 + nb], ck);
			chk("tx count", i_resp.seen.size(), nb + 3);
		end
		apb(1'b0, base + 12'h018, 0, r);
		chk("err", r[3:0], err);
		apb(1'b0, base + 12'h014, 0, r);
		chk("stat", r[1:0], err != 0 ? 2'b00 : {~dir, dir});
		chk("not empty", r[2], !dir && mode != 2);
		chk("irq", irq, ie);
		if (err == 0) begin
			apb(1'b0, base + 12'h008, 0, r);
			chk("id copy", r[5:0], id);
			apb(1'b0, base + 12'h020, 0, d0);
			apb(1'b0, base + 12'h024, 0, d1);
			for (int i = 0; i < nb; i++) chk("buffer", 8'({d1, d0} >> (8 * i)), q[i]);
			apb(1'b0, base + 12'h010, 0, r);
			if (!dir) chk("cks field", r[7:0], rck);
		end
		wr(base + 12'h014, 32'h3);
		wr(base + 12'h018, 32'hf);
		apb(1'b0, base + 12'h014, 0, r);
		chk("stat clear", r[1:0], 2'b00);
		chk("irq clear", irq, 1'b0);
		$display("frame %0d done", k);
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	initial begin : main
		logic [31:0] r;
		seed = 32'h0000fe89;
		{rst, psel, penable, pwrite, paddr, pwdata, sel, arm, gap, resp_n, resp} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int ch = 0; ch < 4; ch++) begin
			for (int j = 0; j < 6; j++) begin
				apb(1'b0, 12'(ch * 64) + {6'h00, offs[j]}, 0, r);
				chk("reset value", r, 32'h0);
			end
		end
		apb(1'b0, 12'h100, 0, r);
		chk("global request", r, 32'h0);
		apb(1'b0, 12'hffc, 0, r);
		chk("unmapped err", last_err, 1'b1);
		$display("register test done");
		for (int k = 0; k < 16; k++) frame(k);
		end_of_test();
	end
endmodule
`default_nettype wire
